// ---- src/dosc_defines.vh ----
/*
  Constants for the synthesizer output and sleep control block: register
  offsets, control-word field positions and reset values.
  Assumes it is included by bare name from the design file under src/.
*/
// Contract
// RQ1: While the internal clock sleeps, the accumulator freezes and the converter holds.
// RQ2: Frequency, phase and control words are still accepted while the clock sleeps.
// RQ3: Register selection by pins or bits keeps working during clock sleep.
// RQ4: Clearing the clock-sleep bit restarts; earlier changes appear after normal latency.
// RQ5: A rising power-down pin reaches the converter without waiting for a sample stage.
// RQ6: A falling power-down pin passes one extra sampling stage before release.
// RQ7: Square output enable bit one drives the pin; zero leaves it undriven.
// RQ8: Host keeps mode bit zero while the square output is enabled.
// RQ9: Enabled, mode zero, source and divide set: pin carries comparator output.
// RQ10: Source select clear and enabled: pin carries converter data MSB.
// RQ11: Rate bit zero gives MSB divided by two, one gives native MSB.
// RQ12: Mode zero sends phase through the sine lookup to the converter.
// RQ13: Mode one bypasses the lookup, giving a ten-bit linear triangle.
// RQ14: Host keeps power-down pin and converter power-down bit low for analog use.
// RQ15: Host may key the frequency select pin between two loaded frequencies.
// RQ16: Reserved output combinations drive a defined low and disturb no state.
// RQ17: Pin-or-software bit picks pin power-down, or separate clock and converter sleep bits.
// RQ18: A sixteen-bit word whose top two bits are 00 loads the control bits.
`ifndef DOSC_DEFINES_VH
`define DOSC_DEFINES_VH

// Register port offsets.
`define DOSC_OFS_WORD 4'h0
`define DOSC_OFS_STATUS 4'h4
`define DOSC_OFS_PHASE 4'h8

// Word type in bits 15:14.
`define DOSC_TYPE_CTRL 2'h0
`define DOSC_TYPE_FREQ0 2'h1
`define DOSC_TYPE_FREQ1 2'h2
`define DOSC_TYPE_PHASE 2'h3

// Control word bit positions, and the register-select bit of a phase word.
`define DOSC_B_B28 13
`define DOSC_B_HLB 12
`define DOSC_B_FSEL 11
`define DOSC_B_PSEL 10
`define DOSC_B_PINSW 9
`define DOSC_B_RESET 8
`define DOSC_B_CLOCK_SLEEP_BIT 7
`define DOSC_B_CONVERTER_POWERDOWN_BIT 6
`define DOSC_B_OPEN 5
`define DOSC_B_SRC 4
`define DOSC_B_RATE 3
`define DOSC_B_MODE 1
`define DOSC_B_PHSEL 13

// Reset values.
`define DOSC_CTRL_RST 14'h0000
`define DOSC_DAC_MID 10'h200

`endif

// ---- src/dosc_control.v ----
/*
  Synthesizer core with output routing and sleep control: accumulator,
  frequency and phase registers, sine or triangle conversion, square-wave
  pin routing and power-down logic, loaded over a plain register port.
  Assumes one 50 MHz clock, a synchronous active-high reset, and that the
  pins freq_sel_pin, phase_sel_pin, powerdown_pin, reset_pin and
  comparator_in arrive from outside this clock domain.
*/
// The address-and-strobe port and the register addresses were decided locally.
`include "dosc_defines.vh"

module dosc_control (
  // Clock and reset.
  input wire clk_sys,
  input wire srst,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Asynchronous device pins.
  input wire freq_sel_pin,
  input wire phase_sel_pin,
  input wire powerdown_pin,
  input wire reset_pin,
  input wire comparator_in,
  // Converter side.
  output reg [9:0] dac_data,
  output reg dac_powerdown,
  // Square-wave pin, two signals.
  output reg square_out,
  output reg square_out_oe
);

  // Two-stage synchronisers for the five pins, one per bit.
  wire [4:0] pin_raw;
  reg [4:0] pin_meta_q;
  reg [4:0] pin_sync_q;
  assign pin_raw = {comparator_in, reset_pin, powerdown_pin, phase_sel_pin, freq_sel_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys) begin
        if (srst) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  wire fsel_pin_s;
  wire psel_pin_s;
  wire pd_pin_s;
  wire rst_pin_s;
  wire cmp_s;
  assign fsel_pin_s = pin_sync_q[0];
  assign psel_pin_s = pin_sync_q[1];
  assign pd_pin_s = pin_sync_q[2];
  assign rst_pin_s = pin_sync_q[3];
  assign cmp_s = pin_sync_q[4];

  // Control and tuning registers.
  reg [13:0] ctrl_q;
  reg [27:0] freq0_q;
  reg [27:0] freq1_q;
  reg [11:0] phase0_q;
  reg [11:0] phase1_q;
  reg [13:0] lsb_hold_q;
  reg lsb_pending_q;

  wire [1:0] word_type;
  wire word_wr;
  assign word_type = reg_wdata[15:14];
  assign word_wr = reg_wr && (reg_addr == `DOSC_OFS_WORD);

  wire b28;
  wire hlb;
  wire pin_or_software_control;
  wire clock_sleep_bit;
  wire converter_powerdown_bit;
  wire square_out_enable;
  wire square_source_select;
  wire msb_rate_select;
  wire wave_mode;
  assign b28 = ctrl_q[`DOSC_B_B28];
  assign hlb = ctrl_q[`DOSC_B_HLB];
  assign pin_or_software_control = ctrl_q[`DOSC_B_PINSW];
  assign clock_sleep_bit = ctrl_q[`DOSC_B_CLOCK_SLEEP_BIT];
  assign converter_powerdown_bit = ctrl_q[`DOSC_B_CONVERTER_POWERDOWN_BIT];
  assign square_out_enable = ctrl_q[`DOSC_B_OPEN];
  assign square_source_select = ctrl_q[`DOSC_B_SRC];
  assign msb_rate_select = ctrl_q[`DOSC_B_RATE];
  assign wave_mode = ctrl_q[`DOSC_B_MODE];

  // Word loading is not gated by sleep, so software may retune a frozen core.
  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= `DOSC_CTRL_RST;
      freq0_q <= 28'h0000000;
      freq1_q <= 28'h0000000;
      phase0_q <= 12'h000;
      phase1_q <= 12'h000;
      lsb_hold_q <= 14'h0000;
      lsb_pending_q <= 1'b0;
    end else if (word_wr) begin // RQ2
      case (word_type)
        `DOSC_TYPE_CTRL: begin
          ctrl_q <= reg_wdata[13:0]; // RQ18
          lsb_pending_q <= 1'b0;
        end
        `DOSC_TYPE_FREQ0, `DOSC_TYPE_FREQ1: begin
          // A full 28-bit load waits for its upper half before it lands.
          if (b28 && !lsb_pending_q) begin
            lsb_hold_q <= reg_wdata[13:0];
            lsb_pending_q <= 1'b1;
          end else if (b28) begin
            lsb_pending_q <= 1'b0;
            if (word_type == `DOSC_TYPE_FREQ0) begin
              freq0_q <= {reg_wdata[13:0], lsb_hold_q};
            end else begin
              freq1_q <= {reg_wdata[13:0], lsb_hold_q};
            end
          end else if (word_type == `DOSC_TYPE_FREQ0) begin
            if (hlb) begin
              freq0_q[27:14] <= reg_wdata[13:0];
            end else begin
              freq0_q[13:0] <= reg_wdata[13:0];
            end
          end else begin
            if (hlb) begin
              freq1_q[27:14] <= reg_wdata[13:0];
            end else begin
              freq1_q[13:0] <= reg_wdata[13:0];
            end
          end
        end
        `DOSC_TYPE_PHASE: begin
          if (reg_wdata[`DOSC_B_PHSEL]) begin
            phase1_q <= reg_wdata[11:0];
          end else begin
            phase0_q <= reg_wdata[11:0];
          end
        end
        default: begin
          lsb_pending_q <= lsb_pending_q;
        end
      endcase
    end
  end

  // Register selection runs on the free synchronising clock, never frozen.
  reg fsel_q;
  reg psel_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      fsel_q <= 1'b0;
      psel_q <= 1'b0;
    end else begin
      fsel_q <= pin_or_software_control ? fsel_pin_s : ctrl_q[`DOSC_B_FSEL]; // RQ3
      psel_q <= pin_or_software_control ? psel_pin_s : ctrl_q[`DOSC_B_PSEL]; // RQ3
    end
  end

  // Power-down sources follow the pin-or-software bit.
  wire core_sleep;
  wire core_reset;
  assign core_sleep = !pin_or_software_control && clock_sleep_bit; // RQ17
  assign core_reset = pin_or_software_control ? rst_pin_s : ctrl_q[`DOSC_B_RESET];

  // Pin assertion goes straight to the output flop; release waits a stage
  // standing in for the falling-edge sample, so short glitches do not wake it.
  reg pd_release_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      pd_release_q <= 1'b0;
      dac_powerdown <= 1'b0;
    end else begin
      pd_release_q <= pd_pin_s;
      if (pin_or_software_control) begin // RQ17
        if (pd_pin_s) begin
          dac_powerdown <= 1'b1; // RQ5
        end else begin
          dac_powerdown <= pd_release_q; // RQ6
        end
      end else begin
        dac_powerdown <= converter_powerdown_bit; // RQ17
      end
    end
  end

  // Accumulator and conversion pipeline; every stage holds while asleep.
  reg [27:0] accum_q;
  reg [11:0] phase_q;
  wire [27:0] freq_sel;
  wire [11:0] phase_off;
  assign freq_sel = fsel_q ? freq1_q : freq0_q;
  assign phase_off = psel_q ? phase1_q : phase0_q;

  always @(posedge clk_sys) begin
    if (srst || core_reset) begin
      accum_q <= 28'h0000000;
      phase_q <= 12'h000;
    end else if (!core_sleep) begin // RQ1
      accum_q <= accum_q + freq_sel;
      phase_q <= accum_q[27:16] + phase_off; // RQ4
    end
  end

  // Parabolic half-wave approximation used as the sine lookup table.
  function [9:0] sine_lookup_table;
    input [11:0] ph;
    reg [9:0] x;
    reg [19:0] prod;
    reg [9:0] mag;
    begin
      x = ph[10:1];
      prod = x * (10'h3ff - x);
      mag = prod[17:8];
      if (ph[11]) begin
        sine_lookup_table = `DOSC_DAC_MID - {1'b0, mag[9:1]};
      end else begin
        sine_lookup_table = `DOSC_DAC_MID + {1'b0, mag[9:1]};
      end
    end
  endfunction

  // Mode chooses the lookup or the linear triangle straight from the phase.
  wire [9:0] tri_wave;
  wire [9:0] wave_next;
  assign tri_wave = phase_q[11] ? ~phase_q[10:1] : phase_q[10:1]; // RQ13
  assign wave_next = wave_mode ? tri_wave : sine_lookup_table(phase_q); // RQ12

  always @(posedge clk_sys) begin
    if (srst || core_reset) begin
      dac_data <= `DOSC_DAC_MID;
    end else if (!core_sleep) begin
      dac_data <= wave_next; // RQ1
    end
  end

  // Divide-by-two of the converter MSB counts rising MSB edges.
  reg msb_prev_q;
  reg msb_div_q;
  always @(posedge clk_sys) begin
    if (srst || core_reset) begin
      msb_prev_q <= 1'b0;
      msb_div_q <= 1'b0;
    end else if (!core_sleep) begin
      msb_prev_q <= dac_data[9];
      if (dac_data[9] && !msb_prev_q) begin
        msb_div_q <= ~msb_div_q;
      end
    end
  end

  // Square pin routing; reserved settings drive a steady low.
  always @(posedge clk_sys) begin
    if (srst) begin
      square_out <= 1'b0;
      square_out_oe <= 1'b0;
    end else begin
      square_out_oe <= square_out_enable; // RQ7
      if (!square_out_enable || wave_mode) begin
        square_out <= 1'b0; // RQ16
      end else if (square_source_select) begin
        square_out <= msb_rate_select ? cmp_s : 1'b0; // RQ9
      end else if (msb_rate_select) begin
        square_out <= dac_data[9]; // RQ10
      end else begin
        square_out <= msb_div_q; // RQ11
      end
    end
  end

  // Read port; unmapped offsets answer zero.
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DOSC_OFS_WORD: begin
          reg_rdata <= {2'b00, ctrl_q};
        end
        `DOSC_OFS_STATUS: begin
          reg_rdata <= {9'h000, lsb_pending_q, psel_q, fsel_q, core_reset,
            dac_powerdown, core_sleep, square_out_oe};
        end
        `DOSC_OFS_PHASE: begin
          reg_rdata <= {4'h0, phase_q};
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // dosc_control

// ---- bench/dosc_control_properties.sv ----
/*
  Checker for the output routing and sleep block, bound to its ports.
  Assumes control words arrive at offset 0x0 with type bits 00.
*/
module dosc_props (
  // Clock and reset.
  input wire clk_sys,
  input wire srst,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  // Pins and outputs.
  input wire powerdown_pin,
  input wire comparator_in,
  input wire [9:0] dac_data,
  input wire dac_powerdown,
  input wire square_out,
  input wire square_out_oe
);
  reg [13:0] ctrl_q;
  // A control write is seen here exactly as the block takes it.
  wire ctrl_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[15:14] == 2'h0;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Shadow of the control bits, so the rules need no view inside.
  always @(posedge clk_sys) begin
    if (srst) ctrl_q <= 14'h0000;
    else if (ctrl_wr) ctrl_q <= reg_wdata[13:0];
  end

  chk_oe_follows: assert property (ctrl_wr |=> ##1 square_out_oe == $past(reg_wdata[5], 2))
    else $error("square enable not followed");
  chk_oe_off: assert property (!ctrl_q[5] [*2] |-> !square_out_oe)
    else $error("square pin driven while disabled");
  chk_pd_rise: assert property ((ctrl_q[9] && powerdown_pin) [*4] |-> dac_powerdown)
    else $error("pin power-down too slow");
  chk_pd_hold: assert property (
    ctrl_q[9] && $fell(powerdown_pin) && dac_powerdown |=> dac_powerdown)
    else $error("pin release not sampled");
  chk_pd_fall: assert property ((ctrl_q[9] && !powerdown_pin) [*5] |-> !dac_powerdown)
    else $error("pin release not applied");
  chk_sw_pd: assert property (
    (!ctrl_q[9] && $stable(ctrl_q)) [*4] |-> dac_powerdown == ctrl_q[6])
    else $error("software power-down wrong");
  chk_sleep_hold: assert property ((!ctrl_q[9] && ctrl_q[7]) [*3] |-> $stable(dac_data))
    else $error("converter moved while asleep");
  chk_reserved_low: assert property (
    (ctrl_q[5] && (ctrl_q[1] || ctrl_q[4] && !ctrl_q[3])) [*3] |-> !square_out)
    else $error("reserved square output not low");
  chk_comp_route: assert property (
    (ctrl_q[5:3] == 3'h7 && !ctrl_q[1] && $stable(comparator_in)) [*5]
    |-> square_out == comparator_in)
    else $error("comparator not routed");
endmodule // dosc_props

bind dosc_control dosc_props chk_u (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .powerdown_pin(powerdown_pin),
  .comparator_in(comparator_in), .dac_data(dac_data), .dac_powerdown(dac_powerdown),
  .square_out(square_out), .square_out_oe(square_out_oe));

// ---- bench/dosc_host_model.sv ----
/*
  Host model: the processor that loads 16-bit words into the block.
  Assumes one clock; strobes change only just after a rising edge.
*/
module dosc_host_model (
  // Clock.
  input wire clk_sys,
  // Register port.
  output logic [3:0] reg_addr = 4'h0,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // One-cycle write; the block never stalls, so the strobe drops at the next edge.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Control words carry type 00; mode stays 0 with the square pin on unless a test asks.
  task automatic ctrl(input logic [13:0] d);
    wr(4'h0, {2'h0, d});
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken then.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // dosc_host_model

// ---- bench/dosc_control_test.sv ----
/*
  Self-checking bench for the output routing and sleep block.
  Assumes the host model drives the register port and this module the pins.
*/
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module dosc_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic freq_sel_pin = 1'b0;
  logic powerdown_pin = 1'b0;
  logic comparator_in = 1'b0;
  logic phase_sel_pin = 1'b0;
  logic reset_pin = 1'b0;
  wire [3:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, dac_powerdown, square_out, square_out_oe;
  wire [9:0] dac_data;
  logic [15:0] rv;
  logic [9:0] held;
  logic sq;
  int n_mismatch = 0, check_count = 0, rises, flips;

  // Free-running 50 MHz clock.
  initial forever #10 clk_sys = ~clk_sys;

  dosc_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dosc_control dut_u (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .freq_sel_pin(freq_sel_pin), .phase_sel_pin(phase_sel_pin), .powerdown_pin(powerdown_pin),
    .reset_pin(reset_pin), .comparator_in(comparator_in), .dac_data(dac_data),
    .dac_powerdown(dac_powerdown), .square_out(square_out), .square_out_oe(square_out_oe));

  // Waits whole cycles, then steps past the edge so outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for the converter MSB; running out ends the run.
  task automatic wait_msb(input logic v);
    int i;
    for (i = 0; i < 2000 && dac_data[9] !== v; i++) tick(1);
    if (i == 2000) begin n_mismatch++; final_report(); end
  endtask

  // Main sequence; the analog outputs are left powered by default.
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    tick(1);
    `CHK(dac_data, 10'h200)
    host_u.ctrl(14'h2000);
    host_u.wr(4'h0, 16'h4000);
    host_u.wr(4'h0, 16'h4040);
    host_u.ctrl(14'h2028);
    tick(2);
    `CHK(square_out_oe, 1'b1)
    wait_msb(1'b1);
    tick(2);
    `CHK(square_out, 1'b1)
    wait_msb(1'b0);
    tick(2);
    `CHK(square_out, 1'b0)
    // Halved MSB: one pin toggle for each MSB rise, over four MSB periods.
    host_u.ctrl(14'h2020);
    // Let the source switch settle so its own pin change is not counted.
    tick(3);
    {rises, flips} = 0;
    repeat (1024) begin
      held = dac_data;
      sq = square_out;
      tick(1);
      rises += int'(!held[9] && dac_data[9]);
      flips += int'(sq != square_out);
    end
    `CHK(1'b1, flips == rises || flips == rises - 1)
    host_u.ctrl(14'h0038);
    @(posedge clk_sys) comparator_in <= 1'b1;
    tick(5);
    `CHK(square_out, 1'b1)
    @(posedge clk_sys) comparator_in <= 1'b0;
    tick(5);
    `CHK(square_out, 1'b0)
    // Reserved selections, the mode one deliberately breaking the host's duty, then the pin disabled.
    @(posedge clk_sys) comparator_in <= 1'b1;
    host_u.ctrl(14'h0030);
    tick(4);
    `CHK(square_out, 1'b0)
    host_u.ctrl(14'h0022);
    tick(4);
    `CHK(square_out, 1'b0)
    host_u.ctrl(14'h0018);
    tick(3);
    `CHK(square_out_oe, 1'b0)
    // Clock sleep: the output holds while words and selection still land.
    host_u.ctrl(14'h0080);
    tick(3);
    held = dac_data;
    host_u.wr(4'h0, 16'h8123);
    host_u.ctrl(14'h0880);
    host_u.rd(4'h4, rv);
    `CHK(rv[4], 1'b1)
    tick(20);
    `CHK(dac_data, held)
    host_u.ctrl(14'h0000);
    tick(10);
    `CHK(1'b1, dac_data !== held)
    // Pin control: keying the select pin, then the power-down pin.
    host_u.ctrl(14'h0200);
    @(posedge clk_sys) freq_sel_pin <= 1'b1;
    tick(3);
    host_u.rd(4'h4, rv);
    `CHK(rv[4], 1'b1)
    @(posedge clk_sys) powerdown_pin <= 1'b1;
    tick(3);
    `CHK(dac_powerdown, 1'b1)
    @(posedge clk_sys) powerdown_pin <= 1'b0;
    tick(3);
    `CHK(dac_powerdown, 1'b1)
    tick(1);
    `CHK(dac_powerdown, 1'b0)
    // Phase select and core reset from their pins while pin control holds.
    @(posedge clk_sys) phase_sel_pin <= 1'b1;
    tick(3);
    host_u.rd(4'h4, rv);
    `CHK(rv[5], 1'b1)
    @(posedge clk_sys) reset_pin <= 1'b1;
    tick(4);
    `CHK(dac_data, 10'h200)
    @(posedge clk_sys) reset_pin <= 1'b0;
    host_u.ctrl(14'h0040);
    tick(3);
    `CHK(dac_powerdown, 1'b1)
    host_u.ctrl(14'h0000);
    tick(3);
    `CHK(dac_powerdown, 1'b0)
    // Triangle mode: away from the turning points each step moves the output by the same amount.
    host_u.ctrl(14'h0002);
    wait_msb(1'b0);
    wait_msb(1'b1);
    held = dac_data;
    tick(1);
    `CHK(1'b1, dac_data - held == 10'h008 || held - dac_data == 10'h008)
    host_u.rd(4'hc, rv);
    `CHK(rv, 16'h0000)
    // A second reset in mid-run brings the converter back to midscale.
    @(posedge clk_sys) srst <= 1'b1;
    tick(2);
    @(posedge clk_sys) srst <= 1'b0;
    tick(1);
    `CHK(dac_data, 10'h200)
    final_report();
  end
endmodule // dosc_control_test
